/* wdsp_apb_front.sv */
// APB slave handshake with zero wait states and registered answer
module wdsp_apb_front (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  wdsp_bus_if.front        bus
);
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdsp_front_t;

  wdsp_front_t q;
  wdsp_front_t d;

  // Answer is prepared in the setup cycle so it stands in the first access cycle
  always_comb begin
    d        = q;
    d.pready = 1'b0;
    if (psel && !penable) begin
      d.pready  = 1'b1;
      d.pslverr = ~bus.hit;
      d.prdata  = (pwrite || !bus.hit) ? 32'h0000_0000 : bus.rdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign bus.addr  = paddr;
  assign bus.wdata = pwdata;
  // Writes land only at the completing edge of the access phase
  assign bus.wr_en = ce & psel & penable & q.pready & pwrite & bus.hit;
  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
endmodule // wdsp_apb_front

/* wdsp_bus_if.sv */
// Decoded register access between the APB front end and the watchdog core
interface wdsp_bus_if;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic [31:0] rdata;
  logic        hit;
  modport front (output addr, output wdata, output wr_en, input rdata, input hit);
  modport core  (input addr, input wdata, input wr_en, output rdata, output hit);
endinterface

/* wdsp_cfg.svh */
// Register offsets, field positions, reset values and counts of the protected watchdog
`ifndef WDSP_CFG_SVH
`define WDSP_CFG_SVH
`define WDSP_OFF_START   8'h00
`define WDSP_OFF_REFRESH 8'h04
`define WDSP_OFF_PROTECT 8'h08
`define WDSP_OFF_CLKMODE 8'h0c
`define WDSP_OFF_PRCMODE 8'h10
`define WDSP_OFF_COUNT   8'h14
`define WDSP_OFF_STATUS  8'h18
`define WDSP_OFF_MASK    8'h1c
`define WDSP_OFF_OPTION  8'h20
`define WDSP_OPTION_ADDR 16'hffff
`define WDSP_OPT_AUTO    0
`define WDSP_OPT_PINIT   7
`define WDSP_PROT_BIT    7
`define WDSP_CLKSTOP_BIT 0
`define WDSP_OSCSTOP_BIT 4
`define WDSP_UFACT_BIT   2
`define WDSP_RUN_BIT     16
`define WDSP_EV_UNDER    0
`define WDSP_EV_REFRESH  1
`define WDSP_EV_BLOCKED  2
`define WDSP_LOAD        12'hfff
`define WDSP_REF_FIRST   8'h00
`define WDSP_REF_SECOND  8'hff
`endif

/* wdsp_edge_sync.sv */
// Three-stage synchroniser that reports accepted rising edges of a foreign clock
module wdsp_edge_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } wdsp_sync_t;

  wdsp_sync_t q;
  wdsp_sync_t d;

  // A change counts only once stages two and three agree
  always_comb begin
    d      = q;
    d.s1   = async_in;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = 1'b0;
    if (q.s2 == q.s3) begin
      d.lvl  = q.s3;
      d.rise = q.s3 & ~q.lvl;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rise = q.rise;
endmodule // wdsp_edge_sync

/* wdsp_pkg.sv */
// Types shared by the protected watchdog modules
package wdsp_pkg;
  // Gray coded along strap, halt, count
  typedef enum logic [1:0] {
    WDSP_ST_STRAP = 2'b00,
    WDSP_ST_HALT  = 2'b01,
    WDSP_ST_COUNT = 2'b11
  } wdsp_run_t;

  typedef struct packed {
    wdsp_run_t   run;
    logic [7:0]  opt;
    logic        protect;
    logic        osc_stop;
    logic        clk_stop;
    logic        uf_action;
    logic        armed;
    logic [11:0] count;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic        irq;
    logic        wdt_rst;
  } wdsp_core_t;
endpackage

/* wdsp_top.sv */
// Watchdog counter in count source protection mode, with APB registers
`include "wdsp_cfg.svh"

// How it works
// - In protection mode the counter steps on slow oscillator edges only.
// - In protection mode the counter decrements over 4096 slow clock periods, no prescaler.
// - Auto-start bit 1 keeps counter halted until count start is written.
// - Auto-start bit 0 starts counting by itself once reset ends.
// - Auto-start bit is option byte bit 0; software cannot write it.
// - Refresh needs write 00h then FFh to the refresh register.
// - Counter reloads on reset, on valid refresh and on underflow.
// - Once started in protection mode, wait mode does not stop counting.
// - Underflow in protection mode always raises the watchdog reset.
// - Enabling protection loads the counter with 0FFFh.
// - Enabling protection clears the slow oscillator stop bit.
// - Enabling protection sets the underflow action bit to reset.
// - In protection mode writes to the all-clock-stop bit are ignored.
// - In protection mode writes to the slow oscillator stop bit are ignored.
// - Protect-init option bit 7 at 0 enables protection at reset.
module wdsp_top
  import wdsp_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        SLOW_OSC_CLK,
  input  wire logic [7:0]  OPTION_BYTE,
  input  wire logic        WAIT_MODE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  output logic             WDT_RST,
  output logic             SLOW_OSC_STOP,
  output logic             STOP_MODE_REQ
);
  wdsp_core_t q;
  wdsp_core_t d;
  logic       slow_tick;
  logic       tick;
  logic       count_en;
  logic       under;
  logic       ref_good;
  logic       wr_start;
  logic       wr_refresh;
  logic       wr_protect;
  logic       wr_clkmode;
  logic       wr_prcmode;
  logic       wr_status;
  logic       wr_mask;
  logic       prot_rise;
  logic [2:0] ev;

  wdsp_bus_if bus ();

  // Slow oscillator arrives from outside, so it is synchronised first
  wdsp_edge_sync u_sync (
    .clk      (REF_CLK),
    .rst      (RST),
    .ce       (CE),
    .async_in (SLOW_OSC_CLK),
    .rise     (slow_tick)
  );

  wdsp_apb_front u_front (
    .clk     (REF_CLK),
    .rst     (RST),
    .ce      (CE),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .bus     (bus.front)
  );

  // Address decode; the option byte has no write decode at all
  always_comb begin
    bus.hit    = 1'b1;
    bus.rdata  = 32'h0000_0000;
    wr_start   = 1'b0;
    wr_refresh = 1'b0;
    wr_protect = 1'b0;
    wr_clkmode = 1'b0;
    wr_prcmode = 1'b0;
    wr_status  = 1'b0;
    wr_mask    = 1'b0;
    if (bus.addr == `WDSP_OFF_START) begin
      wr_start = bus.wr_en;
    end else if (bus.addr == `WDSP_OFF_REFRESH) begin
      wr_refresh = bus.wr_en;
    end else if (bus.addr == `WDSP_OFF_PROTECT) begin
      wr_protect                    = bus.wr_en;
      bus.rdata[`WDSP_PROT_BIT]     = q.protect;
    end else if (bus.addr == `WDSP_OFF_CLKMODE) begin
      wr_clkmode                    = bus.wr_en;
      bus.rdata[`WDSP_CLKSTOP_BIT]  = q.clk_stop;
      bus.rdata[`WDSP_OSCSTOP_BIT]  = q.osc_stop;
    end else if (bus.addr == `WDSP_OFF_PRCMODE) begin
      wr_prcmode                    = bus.wr_en;
      bus.rdata[`WDSP_UFACT_BIT]    = q.uf_action;
    end else if (bus.addr == `WDSP_OFF_COUNT) begin
      bus.rdata[11:0]               = q.count;
      bus.rdata[`WDSP_RUN_BIT]      = (q.run == WDSP_ST_COUNT);
    end else if (bus.addr == `WDSP_OFF_STATUS) begin
      wr_status                     = bus.wr_en;
      bus.rdata[2:0]                = q.status;
    end else if (bus.addr == `WDSP_OFF_MASK) begin
      wr_mask                       = bus.wr_en;
      bus.rdata[2:0]                = q.mask;
    end else if (bus.addr == `WDSP_OFF_OPTION) begin
      bus.rdata[7:0]                = q.opt;
    end else begin
      bus.hit = 1'b0;
    end
  end

  // Count source and gating
  always_comb begin
    // Without protection the slow source is not used; count every cycle
    tick     = q.protect ? slow_tick : 1'b1;
    // Wait mode only freezes the counter when protection is off
    count_en = (q.run == WDSP_ST_COUNT) && (q.protect || !WAIT_MODE);
    under    = count_en && tick && (q.count == 12'h000);
    // Second half of the refresh pair only counts after a clean first half
    ref_good = wr_refresh && q.armed && (bus.wdata[7:0] == `WDSP_REF_SECOND);
    prot_rise = wr_protect && bus.wdata[`WDSP_PROT_BIT] && !q.protect;
  end

  // Core next-state
  always_comb begin
    d         = q;
    d.wdt_rst = 1'b0;
    ev        = 3'b000;
    case (q.run)
      WDSP_ST_STRAP: begin
        // Option byte is sampled once, after reset has been released
        d.opt = OPTION_BYTE;
        if (OPTION_BYTE[`WDSP_OPT_PINIT] == 1'b0) begin
          d.protect   = 1'b1;
          d.count     = `WDSP_LOAD;
          d.osc_stop  = 1'b0;
          d.uf_action = 1'b1;
        end
        if (OPTION_BYTE[`WDSP_OPT_AUTO] == 1'b1) begin
          d.run = WDSP_ST_HALT;
        end else begin
          d.run = WDSP_ST_COUNT;
        end
      end
      WDSP_ST_HALT: begin
        // Counter stays frozen until the start write
        if (wr_start) begin
          d.run = WDSP_ST_COUNT;
        end
      end
      WDSP_ST_COUNT: begin
        if (under) begin
          d.count             = `WDSP_LOAD;
          ev[`WDSP_EV_UNDER]  = 1'b1;
          // Underflow becomes a reset request once the action bit selects it
          d.wdt_rst           = q.uf_action | q.protect;
        end else if (count_en && tick) begin
          d.count = q.count - 12'h001;
        end
      end
      default: begin
        d.run = WDSP_ST_STRAP;
      end
    endcase

    // Refresh sequencing; any other value breaks the pair
    if (wr_refresh) begin
      d.armed = (bus.wdata[7:0] == `WDSP_REF_FIRST);
    end
    if (ref_good) begin
      d.count              = `WDSP_LOAD;
      ev[`WDSP_EV_REFRESH] = 1'b1;
    end

    // Protection is set-only; only a reset takes it away again
    if (prot_rise) begin
      d.protect   = 1'b1;
      d.count     = `WDSP_LOAD;
      d.osc_stop  = 1'b0;
      d.uf_action = 1'b1;
    end

    // Clock mode bits are locked once protection is on
    if (wr_clkmode) begin
      if (!q.protect && !prot_rise) begin
        d.clk_stop = bus.wdata[`WDSP_CLKSTOP_BIT];
        d.osc_stop = bus.wdata[`WDSP_OSCSTOP_BIT];
      end else if (bus.wdata[`WDSP_CLKSTOP_BIT] != q.clk_stop ||
                   bus.wdata[`WDSP_OSCSTOP_BIT] != q.osc_stop) begin
        ev[`WDSP_EV_BLOCKED] = 1'b1;
      end
    end

    // Underflow action is only software-owned outside protection
    if (wr_prcmode && !q.protect && !prot_rise) begin
      d.uf_action = bus.wdata[`WDSP_UFACT_BIT];
    end

    // Sticky events: a new event wins over a write-one clear
    if (wr_status) begin
      d.status = q.status & ~bus.wdata[2:0];
    end
    d.status = d.status | ev;
    if (wr_mask) begin
      d.mask = bus.wdata[2:0];
    end
    d.irq = |(d.status & d.mask);
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q           <= '0;
      q.run       <= WDSP_ST_STRAP;
      q.count     <= `WDSP_LOAD;
    end else if (CE) begin
      q <= d;
    end
  end

  assign IRQ           = q.irq;
  assign WDT_RST       = q.wdt_rst;
  assign SLOW_OSC_STOP = q.osc_stop;
  assign STOP_MODE_REQ = q.clk_stop;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  load_on_enable_a: assert property ($rose(q.protect) |-> q.count == 12'hfff)
    else $error("Counter not loaded when protection enabled");

  osc_on_enable_a: assert property ($rose(q.protect) |-> !q.osc_stop)
    else $error("Slow oscillator stop bit not cleared on protection");

  action_set_a: assert property ($rose(q.protect) |-> q.uf_action)
    else $error("Underflow action not forced to reset");

  stop_locked_a: assert property (q.protect |=> $stable(q.clk_stop))
    else $error("All-clock-stop bit changed in protection mode");

  osc_locked_a: assert property (q.protect |=> !q.osc_stop)
    else $error("Slow oscillator stopped in protection mode");

  under_reset_a: assert property (CE && q.protect && under |=> WDT_RST && q.count == 12'hfff)
    else $error("Protected underflow gave no reset or reload");

  refresh_load_a: assert property (CE && ref_good |=> q.count == 12'hfff)
    else $error("Valid refresh did not reload counter");

  halt_hold_a: assert property (q.run == WDSP_ST_HALT && !wr_start |=> $stable(q.count))
    else $error("Counter moved before count start");

  // A refresh landing on a tick reloads instead, so it is left out here
  wait_count_a: assert property (CE && q.protect && q.run == WDSP_ST_COUNT && slow_tick
                                 && !ref_good && q.count != 12'h000
                                 |=> q.count == $past(q.count) - 12'h001)
    else $error("Protected counter missed a slow tick");

  pulse_single_a: assert property (WDT_RST |=> !WDT_RST)
    else $error("Watchdog reset longer than one cycle");
endmodule // wdsp_top

/* wdsp_top_test.sv */
// Self-checking testbench for the protected watchdog, driven over APB
`include "wdsp_cfg.svh"
module wdsp_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        REF_CLK, RST, CE, SLOW_OSC_CLK, WAIT_MODE;
  logic [7:0]  OPTION_BYTE, PADDR;
  logic        PSEL, PENABLE, PWRITE;
  logic [31:0] PWDATA, PRDATA;
  logic        PREADY, PSLVERR, IRQ, WDT_RST, SLOW_OSC_STOP, STOP_MODE_REQ;
  int          miscompares = 0;
  int          checks = 0;
  logic [31:0] rv;
  logic        er;

  wdsp_top wdsp_top_i (
    .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .SLOW_OSC_CLK(SLOW_OSC_CLK),
    .OPTION_BYTE(OPTION_BYTE), .WAIT_MODE(WAIT_MODE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .WDT_RST(WDT_RST), .SLOW_OSC_STOP(SLOW_OSC_STOP),
    .STOP_MODE_REQ(STOP_MODE_REQ)
  );

  // 20 MHz bus clock
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  // Slow oscillator, 10 bus cycles a period; odd start keeps its edges off the bus clock
  initial begin
    SLOW_OSC_CLK = 1'b0;
    #13;
    forever #250 SLOW_OSC_CLK = ~SLOW_OSC_CLK;
  end

  // Verdict and end of run; timeouts come here too
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rv = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      $display("ERROR pready expected 1 seen timeout");
      end_sim();
    end
  endtask

  // Reset with a given option strap, held two cycles
  task automatic do_reset(input logic [7:0] opt);
    OPTION_BYTE <= opt;
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
  endtask

  // Halted start, read-only option byte, unmapped address, software start
  task automatic t_start;
    do_reset(8'hff);
    chk("wdt_rst", 32'h0, {31'h0, WDT_RST});
    apb(1'b0, `WDSP_OFF_OPTION, 32'h0);
    chk("option", 32'hff, rv);
    apb(1'b1, `WDSP_OFF_OPTION, 32'h0);
    apb(1'b0, `WDSP_OFF_OPTION, 32'h0);
    chk("option kept", 32'hff, rv);
    repeat (50) @(posedge REF_CLK);
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    chk("count halted", 32'hfff, rv);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rv);
    apb(1'b1, `WDSP_OFF_START, 32'h0);
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    chk("running", 32'h1, {31'h0, rv[16]});
  endtask

  // Enabling protection and the blocked clock-mode writes, with interrupt
  task automatic t_protect;
    apb(1'b1, `WDSP_OFF_CLKMODE, 32'h10);
    @(posedge REF_CLK);
    chk("osc stop set", 32'h1, {31'h0, SLOW_OSC_STOP});
    apb(1'b1, `WDSP_OFF_PROTECT, 32'h80);
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    chk("reload", 32'h1, {31'h0, rv[11:0] >= 12'hffe});
    chk("osc on", 32'h0, {31'h0, SLOW_OSC_STOP});
    apb(1'b0, `WDSP_OFF_PRCMODE, 32'h0);
    chk("uf action", 32'h4, rv);
    apb(1'b1, `WDSP_OFF_MASK, 32'h4);
    apb(1'b1, `WDSP_OFF_CLKMODE, 32'h11);
    @(posedge REF_CLK);
    chk("stop req", 32'h0, {31'h0, STOP_MODE_REQ});
    chk("osc stop", 32'h0, {31'h0, SLOW_OSC_STOP});
    chk("irq on", 32'h1, {31'h0, IRQ});
    apb(1'b1, `WDSP_OFF_STATUS, 32'h4);
    @(posedge REF_CLK);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
  endtask

  // Refresh needs 00h then FFh; a lone FFh is no refresh
  task automatic t_refresh;
    repeat (300) @(posedge REF_CLK);
    apb(1'b1, `WDSP_OFF_REFRESH, 32'h0);
    apb(1'b1, `WDSP_OFF_REFRESH, 32'hff);
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    chk("refreshed", 32'h1, {31'h0, rv[11:0] >= 12'hffe});
    repeat (300) @(posedge REF_CLK);
    apb(1'b1, `WDSP_OFF_REFRESH, 32'hff);
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    chk("no refresh", 32'h1, {31'h0, rv[11:0] < 12'hff0});
  endtask

  // Wait mode must not stop the count once protected
  task automatic t_wait;
    logic [11:0] c1;
    WAIT_MODE <= 1'b1;
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    c1 = rv[11:0];
    repeat (200) @(posedge REF_CLK);
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    chk("wait counts", 32'h1, {31'h0, rv[11:0] < c1});
    WAIT_MODE <= 1'b0;
  endtask

  // Protection and auto-start from the strap; full period to the reset pulse
  task automatic t_underflow;
    int n;
    do_reset(8'h7e);
    n = 0;
    while (WDT_RST !== 1'b1 && n < 50000) begin
      @(posedge REF_CLK);
      n++;
    end
    // 4096 ticks of ten cycles, plus sync latency and first-edge phase
    chk("period", 32'h1, {31'h0, n >= 40930 && n <= 40980});
    @(posedge REF_CLK);
    chk("pulse end", 32'h0, {31'h0, WDT_RST});
    apb(1'b0, `WDSP_OFF_COUNT, 32'h0);
    chk("uf reload", 32'h1, {31'h0, rv[11:0] >= 12'hffe});
    apb(1'b0, `WDSP_OFF_PROTECT, 32'h0);
    chk("protect init", 32'h80, rv);
    apb(1'b0, `WDSP_OFF_STATUS, 32'h0);
    chk("uf status", 32'h1, {31'h0, rv[0]});
  endtask

  // Main sequence
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    WAIT_MODE = 1'b0;
    OPTION_BYTE = 8'hff;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    t_start();
    t_protect();
    t_refresh();
    t_wait();
    t_underflow();
    end_sim();
  end
endmodule // wdsp_top_test
